// ===== verilog/sbl_loader.sv
// serial boot loader: picks an action from the first received
// character, downloads a program into ram and echoes it back
// assumes rxd is asynchronous and the txd pin has an external pullup
`timescale 1ns/1ps
module sbl_loader #(
	parameter bit          VARIABLE  = 1'b1,            // variable length
	parameter int unsigned MAX_LEN   = sbl_pkg::MAX_LEN, // ram bytes
	parameter int unsigned DIV_SLOW  = sbl_pkg::DIV_SLOW, // slow bit time
	parameter int unsigned IDLE_FAST = sbl_pkg::IDLE_FAST, // gap, fast
	parameter int unsigned IDLE_SLOW = sbl_pkg::IDLE_SLOW  // gap, slow
) (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        rxd,
	input  wire logic        txd_in,
	output logic             txd_out,
	output logic             txd_oe_n,
	output logic             async_serial_port_rx_en,
	output logic             async_serial_port_tx_en,
	output logic             serial_pins_owned,
	output logic             baud_slow,
	output logic             jump_to_target,
	output logic [15:0]      jump_addr,
	output logic [10:0]      load_len,
	input  wire logic [7:0]  prog_rd_addr,
	output logic [7:0]       prog_rd_data
);
	localparam int unsigned CW = sbl_pkg::CW;
	initial begin
		if (MAX_LEN == 0 || MAX_LEN > 256)
			$error("sbl_loader: length must be 1..256");
		if (DIV_SLOW < 4 || IDLE_SLOW >= (1 << CW) || IDLE_FAST >= (1 << CW))
			$error("sbl_loader: timing counts out of range");
	end

	typedef enum logic [3:0] {
		SBL_BRK   = 4'h1, // sending the start-up break
		SBL_FIRST = 4'h2, // waiting for the first character
		SBL_LOAD  = 4'h4, // downloading
		SBL_JUMP  = 4'h8  // handed over to the target
	} sbl_state_t;

	sbl_state_t state, next_state; // main sequencer

	// --- pin synchroniser: three flops, change taken when 2 and 3 agree
	logic rx_m1, rx_m2, rx_m3; // sync chain
	logic rx_s, rx_prev;       // filtered level and its last value
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			{rx_m1, rx_m2, rx_m3} <= 3'h7;
			rx_s    <= 1'b1;
			rx_prev <= 1'b1;
		end else begin
			rx_m1   <= rxd;
			rx_m2   <= rx_m1;
			rx_m3   <= rx_m2;
			rx_s    <= (rx_m2 == rx_m3) ? rx_m3 : rx_s;
			rx_prev <= rx_s;
		end
	end

	// --- bit timing follows the selected rate
	wire [CW-1:0] bit_div  = baud_slow ? CW'(DIV_SLOW)
	                                   : CW'(sbl_pkg::DIV_FAST);
	wire [CW-1:0] idle_lim = baud_slow ? CW'(IDLE_SLOW) : CW'(IDLE_FAST);
	wire          rx_fall  = rx_prev & ~rx_s; // a line held low fires only once, even when low out of reset

	// --- receiver: sample mid-bit, lsb first
	logic          rx_busy;   // inside a frame
	logic [3:0]    rx_idx;    // bit index, 0 is the start bit
	logic [CW-1:0] rx_cnt;    // cycles to the next sample
	logic [7:0]    rx_sh;     // data shifter
	logic          rx_done;   // one-cycle pulse, frame complete
	logic          rx_stop;   // stop bit seen high with rx_done
	wire           rx_tick = rx_busy && rx_cnt == '0;
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rx_busy <= 1'b0;
			rx_idx  <= 4'h0;
			rx_cnt  <= '0;
			rx_sh   <= 8'h00;
			rx_done <= 1'b0;
			rx_stop <= 1'b0;
		end else begin
			rx_done <= 1'b0;
			if (!rx_busy && rx_fall) begin
				rx_busy <= 1'b1;
				rx_idx  <= 4'h0;
				rx_cnt  <= bit_div >> 1;
			end else if (rx_tick) begin
				rx_cnt <= bit_div - CW'(1);
				rx_idx <= rx_idx + 4'h1;
				if (rx_idx == 4'h0 && rx_s) begin
					rx_busy <= 1'b0; // glitch, not a start bit
				end else if (rx_idx == sbl_pkg::RX_STOP) begin
					rx_busy <= 1'b0;
					rx_done <= 1'b1;
					rx_stop <= rx_s; // low stop with zero data is a break
				end else if (rx_idx != 4'h0) begin
					rx_sh <= {rx_s, rx_sh[7:1]};
				end
			end else if (rx_busy) begin
				rx_cnt <= rx_cnt - CW'(1);
			end
		end
	end

	// --- two-entry buffer between receiver and ram/echo
	logic [7:0] buf0, buf1;  // head and second entry
	logic [1:0] buf_cnt;     // entries held
	logic       tx_busy;     // transmitter shifting
	logic [8:0] wr_count;    // bytes stored so far
	wire buf_in_ready  = buf_cnt != 2'h2;
	wire buf_out_valid = buf_cnt != 2'h0;
	wire room          = wr_count < 9'(MAX_LEN);
	wire buf_push = state == SBL_LOAD && rx_done && rx_stop && buf_in_ready;
	// a busy echo stalls the drain; bytes past the limit are dropped
	wire buf_pop  = buf_out_valid && (!tx_busy || !room);
	wire store    = buf_pop && room;
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			buf0    <= 8'h00;
			buf1    <= 8'h00;
			buf_cnt <= 2'h0;
		end else begin
			buf_cnt <= buf_cnt + {1'b0, buf_push} - {1'b0, buf_pop};
			if (buf_pop)
				buf0 <= (buf_push && buf_cnt == 2'h1) ? rx_sh : buf1;
			else if (buf_push && buf_cnt == 2'h0)
				buf0 <= rx_sh;
			if (buf_push && (buf_cnt - {1'b0, buf_pop}) == 2'h1)
				buf1 <= rx_sh;
		end
	end

	// --- transmitter; leaves reset already sending the break
	logic [9:0]    tx_sh;   // frame shifter, lsb goes out first
	logic [3:0]    tx_left; // bits still to send
	logic [CW-1:0] tx_cnt;  // cycles left in this bit
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			tx_busy <= 1'b1;
			tx_sh   <= 10'h000;
			tx_left <= sbl_pkg::TX_BITS;
			tx_cnt  <= CW'(sbl_pkg::DIV_FAST - 1);
		end else if (store) begin
			tx_busy <= 1'b1;
			tx_sh   <= {1'b1, buf0, 1'b0};
			tx_left <= sbl_pkg::TX_BITS;
			tx_cnt  <= bit_div - CW'(1);
		end else if (tx_busy) begin
			if (tx_cnt == '0) begin
				tx_cnt  <= bit_div - CW'(1);
				// refill with the top bit: ones after a frame, zeros while
				// the break runs, so the break stays low for all ten bits
				tx_sh   <= {tx_sh[9], tx_sh[9:1]};
				tx_left <= tx_left - 4'h1;
				tx_busy <= tx_left != 4'h1;
			end else begin
				tx_cnt <= tx_cnt - CW'(1);
			end
		end
	end
	// open drain: only ever pulls low, released means pulled up outside
	assign txd_out  = 1'b0;
	assign txd_oe_n = !tx_busy || tx_sh[0];

	// --- end-of-download idle timer, cleared by any line activity
	logic [CW-1:0] idle_cnt; // cycles of quiet line
	wire idle_hit = VARIABLE && idle_cnt == idle_lim;
	always_ff @(posedge core_clk) begin
		if (!rst_n || state != SBL_LOAD || rx_busy || rx_fall)
			idle_cnt <= '0;
		else if (!idle_hit)
			idle_cnt <= idle_cnt + CW'(1);
	end

	// --- sequencer decisions
	wire first_ok = (state == SBL_BRK || state == SBL_FIRST) && rx_done;
	wire is_zero  = rx_sh == sbl_pkg::CODE_EEPROM; // zero data or break
	wire is_ram   = rx_sh == sbl_pkg::CODE_RAM && rx_stop;
	wire is_fast  = rx_sh == sbl_pkg::SYNC_FAST && rx_stop;
	wire is_slow  = rx_sh == sbl_pkg::SYNC_SLOW && rx_stop;
	wire drained  = !buf_out_valid && !tx_busy && !buf_push;
	// variable mode ends on quiet line or full ram; fixed only on full
	wire load_end = state == SBL_LOAD && drained &&
	                (idle_hit || !room);

	always_comb begin
		next_state = state;
		unique case (state)
			SBL_BRK:   if (first_ok && (is_zero || is_ram))
			               next_state = SBL_JUMP;
			           else if (first_ok && (is_fast || is_slow))
			               next_state = SBL_LOAD;
			           else if (!tx_busy)
			               next_state = SBL_FIRST;
			SBL_FIRST: if (first_ok && (is_zero || is_ram))
			               next_state = SBL_JUMP;
			           else if (first_ok && (is_fast || is_slow))
			               next_state = SBL_LOAD;
			SBL_LOAD:  if (load_end)
			               next_state = SBL_JUMP;
			SBL_JUMP:  next_state = SBL_JUMP;
			default:   next_state = SBL_BRK;
		endcase
	end

	// state, jump target, rate and counters
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state          <= SBL_BRK;
			jump_to_target <= 1'b0;
			jump_addr      <= 16'h0000;
			baud_slow      <= 1'b0;
			wr_count       <= 9'h000;
			serial_pins_owned <= 1'b0;
		end else begin
			state             <= next_state;
			serial_pins_owned <= 1'b1;
			if (first_ok && is_zero) begin
				jump_to_target <= 1'b1;
				jump_addr      <= sbl_pkg::EEPROM_BASE;
			end else if (first_ok && is_ram) begin
				jump_to_target <= 1'b1;
				jump_addr      <= sbl_pkg::RAM_BASE;
			end else if (load_end) begin
				jump_to_target <= 1'b1;
				jump_addr      <= sbl_pkg::RAM_BASE;
			end
			if (first_ok && !is_zero && !is_ram && (is_fast || is_slow))
				baud_slow <= is_slow;
			if (store)
				wr_count <= wr_count + 9'h001;
		end
	end
	assign async_serial_port_rx_en = serial_pins_owned;
	assign async_serial_port_tx_en = serial_pins_owned;
	assign load_len = {2'b00, wr_count};

	sbl_ram #(.WIDTH(8), .DEPTH(256), .AW(8)) u_ram (
		.core_clk (core_clk),
		.wr_en    (store),
		.wr_addr  (wr_count[7:0]),
		.wr_data  (buf0),
		.rd_addr  (prog_rd_addr),
		.rd_data  (prog_rd_data)
	);

	// --- checks
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	chk_eeprom_jump: assert property (first_ok && is_zero |=>
		jump_to_target && jump_addr == sbl_pkg::EEPROM_BASE)
		else $error("zero first char did not jump to eeprom");
	chk_ram_jump: assert property (first_ok && is_ram |=>
		jump_to_target && jump_addr == sbl_pkg::RAM_BASE
		&& state == SBL_JUMP)
		else $error("55 first char did not jump to ram");
	chk_start_break: assert property (state == SBL_BRK && tx_busy |->
		!txd_oe_n) else $error("start break not driven low");
	chk_open_drain: assert property (txd_out == 1'b0)
		else $error("transmit pin driven high");
	chk_rx_start_edge: assert property ($rose(rx_busy) |->
		$past(rx_prev) && !$past(rx_s))
		else $error("receiver started without a falling edge");
	chk_fixed_len: assert property (!VARIABLE && load_end |->
		wr_count == 9'(MAX_LEN))
		else $error("fixed download ended at wrong count");
	chk_idle_end: assert property (idle_hit && drained
		&& state == SBL_LOAD |=> state == SBL_JUMP && jump_to_target)
		else $error("idle line did not end download");
	chk_idle_armed: assert property (state != SBL_LOAD |=>
		idle_cnt == '0) else $error("idle timer ran before sync");
	chk_echo_start: assert property (store |=> tx_busy &&
		tx_sh[8:1] == $past(buf0))
		else $error("stored byte not echoed");
	chk_ram_seq: assert property (store |=>
		wr_count == $past(wr_count) + 9'h001)
		else $error("ram address did not advance");
	chk_sync_rate: assert property (state != SBL_LOAD ##1
		state == SBL_LOAD |-> baud_slow == $past(is_slow))
		else $error("rate not taken from sync code");
	cov_eeprom: cover property (first_ok && is_zero);
	cov_ram: cover property (first_ok && is_ram);
	cov_load_idle: cover property (load_end && idle_hit);
	cov_buf_full: cover property (buf_cnt == 2'h2);
endmodule

// ===== verilog/sbl_pkg.sv
// constants shared by the serial boot loader and its test bench
// assumes a 25 MHz core clock and an 8N1 character frame on the link
package sbl_pkg;
	localparam int unsigned CLK_HZ     = 25_000_000; // core clock rate
	localparam int unsigned BAUD_FAST  = 7812;       // default link rate
	localparam int unsigned BAUD_SLOW  = 1200;       // alternate link rate
	localparam int unsigned DIV_FAST   = CLK_HZ / BAUD_FAST; // cycles/bit
	localparam int unsigned DIV_SLOW   = CLK_HZ / BAUD_SLOW; // cycles/bit
	localparam int unsigned CHAR_BITS  = 10;         // start, 8 data, stop
	localparam int unsigned IDLE_CHARS = 4;          // end-of-load gap
	localparam int unsigned IDLE_FAST  = IDLE_CHARS * CHAR_BITS * DIV_FAST;
	localparam int unsigned IDLE_SLOW  = IDLE_CHARS * CHAR_BITS * DIV_SLOW;
	localparam int unsigned MAX_LEN    = 256;        // longest download
	localparam int unsigned CW         = 20;         // timer width
	localparam logic [7:0]  CODE_EEPROM = 8'h00;     // jump to eeprom
	localparam logic [7:0]  CODE_RAM    = 8'h55;     // jump to ram
	localparam logic [7:0]  SYNC_FAST   = 8'hFF;     // sync at default rate
	localparam logic [7:0]  SYNC_SLOW   = 8'hE0;     // slow sync as sampled
	localparam logic [15:0] EEPROM_BASE = 16'hB600;  // eeprom start
	localparam logic [15:0] RAM_BASE    = 16'h0000;  // ram start
	localparam logic [3:0]  TX_BITS     = 4'hA;      // bits per sent char
	localparam logic [3:0]  RX_STOP     = 4'h9;      // index of stop bit
endpackage

// ===== verilog/sbl_ram.sv
// program memory that the loader fills; one write port, one read port
// assumes a single clock; read data appear one cycle after the address
`timescale 1ns/1ps
module sbl_ram #(
	parameter int unsigned WIDTH = 8,   // word width
	parameter int unsigned DEPTH = 256, // words held
	parameter int unsigned AW    = 8    // address width
) (
	input  wire logic             core_clk,
	input  wire logic             wr_en,
	input  wire logic [AW-1:0]    wr_addr,
	input  wire logic [WIDTH-1:0] wr_data,
	input  wire logic [AW-1:0]    rd_addr,
	output logic      [WIDTH-1:0] rd_data
);
	initial begin
		if (DEPTH > (1 << AW) || DEPTH == 0)
			$error("sbl_ram: depth does not fit the address width");
	end

	logic [WIDTH-1:0] mem [DEPTH]; // storage, no reset so it maps to ram

	// write port; read data come from a register for timing
	always_ff @(posedge core_clk) begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
		rd_data <= mem[rd_addr];
	end
endmodule

// ===== bench/sbl_host.sv
// host model on the far end of the serial link: sends 8N1 characters
// and decodes whatever the loader puts on its open-drain transmit wire
`timescale 1ns/1ps
module sbl_host (
	input  wire logic core_clk,
	input  wire logic txd_wire,
	output logic      rxd
);
	int unsigned div = sbl_pkg::DIV_FAST; // cycles per bit, set by bench
	logic [7:0]  echo_q[$];               // characters seen coming back
	logic [7:0]  cap;                     // echo being shifted in
	int          i;                       // echo bit index

	// the line idles high between characters
	initial rxd = 1'b1;

	// one character, lsb first, each bit held a full bit time
	task automatic send(input logic [7:0] data);
		logic [9:0] f;
		f = {1'b1, data, 1'b0};
		for (int b = 0; b < 10; b++) begin
			rxd <= f[b];
			repeat (div) @(posedge core_clk);
		end
	endtask

	// echo receiver: mid-bit sampling; a low stop bit (break) is dropped
	always begin
		@(negedge txd_wire);
		repeat (div / 2) @(posedge core_clk);
		for (i = 0; i < 8; i++) begin
			repeat (div) @(posedge core_clk);
			cap[i] = txd_wire;
		end
		repeat (div) @(posedge core_clk);
		if (txd_wire === 1'b1) begin
			echo_q.push_back(cap);
		end
	end
endmodule

// ===== bench/serial_boot_loader_test.sv
// self-checking bench: a variable-length loader and a short fixed-length
// one share the host's receive line; the slow bit time is shortened
`timescale 1ns/1ps
module serial_boot_loader_test;
	// shortened slow bit; four slow chars must outlast the half fast bit
	// left after the sync's mid-stop sample, or the load ends empty
	localparam int unsigned DIV_S  = 48;
	localparam int unsigned IDLE_S = 40 * DIV_S; // four chars at that rate
	logic        core_clk = 1'b0;   // 25 MHz clock
	logic        rst_n = 1'b0;      // synchronous reset
	logic        loop = 1'b0;       // ties rxd to the transmit wire
	logic [7:0]  prog_rd_addr = 8'h00; // ram read address
	logic        txd_out, txd_oe_n, rx_en, tx_en, owned, baud_slow, jump;
	logic        txd_out2, txd_oe_n2, jump2;
	logic [15:0] jump_addr, jump_addr2; // handover targets
	logic [10:0] load_len, load_len2;   // bytes stored
	logic [7:0]  prog_rd_data;          // ram read data
	logic        host_rxd;              // host drive of the line
	logic [31:0] seed = 32'hA2BB596D;   // xorshift state
	logic [7:0]  sent[$];               // reference copy of the program
	int          n_errors = 0;
	int          check_count = 0;
	int          cycles = 0;
	// open drain with pullup: only a low is ever driven
	wire txd_wire  = !txd_oe_n ? txd_out : 1'b1;
	wire txd_wire2 = !txd_oe_n2 ? txd_out2 : 1'b1;
	wire dut_rxd   = loop ? txd_wire : host_rxd;

	always #20 core_clk = ~core_clk;

	sbl_loader #(.DIV_SLOW(DIV_S), .IDLE_SLOW(IDLE_S)) u_dut (
		.core_clk(core_clk), .rst_n(rst_n), .rxd(dut_rxd),
		.txd_in(txd_wire), .txd_out(txd_out), .txd_oe_n(txd_oe_n),
		.async_serial_port_rx_en(rx_en), .async_serial_port_tx_en(tx_en),
		.serial_pins_owned(owned), .baud_slow(baud_slow),
		.jump_to_target(jump), .jump_addr(jump_addr), .load_len(load_len),
		.prog_rd_addr(prog_rd_addr), .prog_rd_data(prog_rd_data));

	// fixed length, shortened to four bytes so the end is reachable
	sbl_loader #(.VARIABLE(1'b0), .MAX_LEN(4), .DIV_SLOW(DIV_S),
		.IDLE_SLOW(IDLE_S)) u_fixed (
		.core_clk(core_clk), .rst_n(rst_n), .rxd(dut_rxd),
		.txd_in(txd_wire2), .txd_out(txd_out2), .txd_oe_n(txd_oe_n2),
		.async_serial_port_rx_en(), .async_serial_port_tx_en(),
		.serial_pins_owned(), .baud_slow(), .jump_to_target(jump2),
		.jump_addr(jump_addr2), .load_len(load_len2),
		.prog_rd_addr(8'h00), .prog_rd_data());

	sbl_host u_host (.core_clk(core_clk), .txd_wire(txd_wire),
		.rxd(host_rxd));

	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	// compare and count; four-state equality so x never matches
	task automatic check(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic stop_test;
		if (n_errors == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// reset for 16 cycles with the line set up as the scenario needs
	task automatic restart(input logic lp, input logic rx);
		@(posedge core_clk);
		rst_n <= 1'b0;
		loop <= lp;
		u_host.rxd <= rx;
		u_host.div = sbl_pkg::DIV_FAST;
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge core_clk);
	endtask

	// bounded wait for the handover, sampled away from the edge
	task automatic wait_jump(input int limit);
		int k;
		k = 0;
		while (jump !== 1'b1 && k < limit) begin
			@(posedge core_clk);
			k++;
		end
		@(negedge core_clk);
	endtask

	// hang guard: a run past the ceiling counts as a mismatch
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 104000) begin
			n_errors++;
			stop_test();
		end
	end

	initial begin
		// loopback: the start-up break must come back as a jump to eeprom
		restart(1'b1, 1'b1);
		repeat (100) @(posedge core_clk);
		check("rx_en", 16'h1, rx_en);
		check("tx_en_owned", 16'h3, {tx_en, owned});
		check("txd_out", 16'h0, txd_out);
		check("break_low", 16'h0, txd_wire);
		wait_jump(40000);
		check("jump_eeprom", 16'h1, jump);
		check("addr_eeprom", sbl_pkg::EEPROM_BASE, jump_addr);
		check("addr_fixed", sbl_pkg::EEPROM_BASE, jump_addr2);

		// line held low from reset, then a late jump-to-ram code
		restart(1'b0, 1'b0);
		repeat (500) @(posedge core_clk);
		check("low_no_char", 16'h0, jump);
		u_host.rxd <= 1'b1;
		repeat (100) @(posedge core_clk);
		u_host.send(sbl_pkg::CODE_RAM);
		wait_jump(4000);
		check("addr_ram", sbl_pkg::RAM_BASE, jump_addr);
		check("len_none", 16'h0, load_len);

		// slow sync, five random bytes back to back, then silence
		restart(1'b0, 1'b1);
		u_host.send(sbl_pkg::SYNC_SLOW);
		u_host.div = DIV_S;
		u_host.echo_q.delete();
		check("baud_slow", 16'h1, baud_slow);
		for (int n = 0; n < 5; n++) begin
			seed = xorshift(seed);
			sent.push_back(seed[7:0]);
			u_host.send(seed[7:0]);
		end
		check("no_early_end", 16'h0, jump);
		wait_jump(IDLE_S + 2000);
		check("addr_load", sbl_pkg::RAM_BASE, jump_addr);
		check("len_short", sent.size(), load_len);
		check("echo_count", sent.size(), u_host.echo_q.size());
		for (int n = 0; n < sent.size(); n++) begin
			check("echo", sent[n], u_host.echo_q[n]);
			@(posedge core_clk);
			prog_rd_addr <= n[7:0];
			repeat (2) @(posedge core_clk);
			@(negedge core_clk);
			check("ram", sent[n], prog_rd_data);
		end
		check("fixed_jump", 16'h1, jump2);
		check("fixed_len", 16'h4, load_len2);
		check("fixed_addr", sbl_pkg::RAM_BASE, jump_addr2);
		stop_test();
	end
endmodule
